/* rtl/irq_enable_pkg.sv */
// Constants shared by the interrupt enable and flag logic
package irq_enable_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] core_ctrl_addr_a = 8'h0b;
  localparam logic [7:0] core_ctrl_addr_b = 8'h8b;
  localparam logic [7:0] periph_en_addr = 8'h8c;
  localparam logic [7:0] periph_flag_addr = 8'h0c;
  localparam logic [7:0] irq_status_addr = 8'h40;
  localparam logic [7:0] irq_mask_addr = 8'h44;

  // ****************************************************************
  // Field positions of core_irq_control
  // ****************************************************************
  localparam int global_request_enable_bit = 7;
  localparam int peripheral_group_enable_bit = 6;
  localparam int timer0_overflow_en_bit = 5;
  localparam int edge_pin_en_bit = 4;
  localparam int port_change_en_bit = 3;
  localparam int timer0_overflow_flag_bit = 2;
  localparam int edge_pin_flag_bit = 1;
  localparam int port_change_flag_bit = 0;

  // ****************************************************************
  // Field positions of peripheral_irq_enables and peripheral_irq_flags
  // ****************************************************************
  localparam int parallel_slave_bit = 7;
  localparam int conversion_done_bit = 6;
  localparam int serial_rx_bit = 5;
  localparam int serial_tx_bit = 4;
  localparam int sync_serial_bit = 3;
  localparam int capture_compare_bit = 2;
  localparam int timer2_match_bit = 1;
  localparam int timer1_overflow_bit = 0;

  // ****************************************************************
  // Reset values and status layout
  // ****************************************************************
  localparam logic [7:0] core_ctrl_reset = 8'h00;
  localparam logic [7:0] periph_en_reset = 8'h00;
  localparam logic [7:0] periph_flag_reset = 8'h00;
  localparam logic [1:0] irq_status_reset = 2'h0;
  localparam logic [1:0] irq_mask_reset = 2'h0;
  localparam int status_core_req_bit = 0;
  localparam int status_periph_req_bit = 1;

  // Bus slave states
  typedef enum logic [1:0] {
    bus_idle = 2'b01,
    bus_ack = 2'b10
  } bus_state_type;

endpackage

/* rtl/change_detect.sv */
// Synchroniser and change detector for external event pins
`timescale 1ns/1ps
module change_detect #(
  parameter int width = 1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [width-1:0] pin_in,
  output logic [width-1:0] rise,
  output logic [width-1:0] fall
);

  logic [width-1:0] meta_q;
  logic [width-1:0] sync_q;
  logic [width-1:0] last_q;
  logic [2:0] armed_q;

  // ****************************************************************
  // Two-stage synchroniser, then one history stage
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edges count only once the pipeline has refilled after reset, so a pin already
  // high at release gives no false edge; only a change before the first clock after release is missed
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_q <= 3'h0;
    end else begin
      armed_q <= {armed_q[1:0], 1'b1};
    end
  end

  assign rise = sync_q & ~last_q & {width{armed_q[2]}};
  assign fall = ~sync_q & last_q & {width{armed_q[2]}};

endmodule

/* rtl/mcu_irq_enable_logic.sv */
// Interrupt enable and flag logic with a classic Wishbone register slave
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module mcu_irq_enable_logic (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic timer0_overflow,
  input wire logic external_edge_pin,
  input wire logic edge_rising,
  input wire logic [3:0] port_upper_pins,
  input wire logic [7:0] peripheral_events,
  input wire logic [7:0] peripheral_levels,
  output logic core_request,
  output logic irq
);
  import irq_enable_pkg::*;

  logic [4:0] core_en_q;
  logic t0_flag_q;
  logic edge_flag_q;
  logic port_flag_q;
  logic [7:0] core_ctrl;
  logic core_bit0_undef_q;
  logic [7:0] periph_en_q;
  logic [7:0] periph_flag_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  bus_state_type bus_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic err_q;
  logic edge_rise;
  logic edge_fall;
  logic [3:0] port_rise;
  logic [3:0] port_fall;
  logic edge_event;
  logic port_event;
  logic core_req;
  logic periph_req;
  logic [7:0] periph_pairs;
  logic [1:0] req_prev_q;
  logic [1:0] req_rise;
  logic bus_req;
  logic wr_stb;
  logic hit_core;
  logic hit_en;
  logic hit_flag;
  logic hit_status;
  logic hit_mask;
  logic mapped;
  logic [7:0] wbyte;
  logic core_wr;
  logic en_wr;
  logic flag_wr;
  logic status_wr;
  logic mask_wr;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] reg_addr);
    addr_hit = (adr == reg_addr);
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i && (bus_q == bus_idle);
  assign hit_core = addr_hit(wb_adr_i, core_ctrl_addr_a) ||
                    addr_hit(wb_adr_i, core_ctrl_addr_b);
  assign hit_en = addr_hit(wb_adr_i, periph_en_addr);
  assign hit_flag = addr_hit(wb_adr_i, periph_flag_addr);
  assign hit_status = addr_hit(wb_adr_i, irq_status_addr);
  assign hit_mask = addr_hit(wb_adr_i, irq_mask_addr);
  assign mapped = hit_core || hit_en || hit_flag || hit_status || hit_mask;
  assign wr_stb = bus_req && wb_we_i && wb_sel_i[0] && mapped;
  assign wbyte = wb_dat_i[7:0];

  // ****************************************************************
  // Register write strobes
  // ****************************************************************
  // Writes land at the edge the request is taken; only byte lane 0 holds a register
  assign core_wr = wr_stb && hit_core;
  assign en_wr = wr_stb && hit_en;
  assign flag_wr = wr_stb && hit_flag;
  assign status_wr = wr_stb && hit_status;
  assign mask_wr = wr_stb && hit_mask;

  // ****************************************************************
  // Event sources
  // ****************************************************************
  change_detect #(
    .width(1)
  ) edge_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_in(external_edge_pin),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  change_detect #(
    .width(4)
  ) port_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_in(port_upper_pins),
    .rise(port_rise),
    .fall(port_fall)
  );

  // Edge polarity lives in another register, so it arrives as a plain input
  assign edge_event = edge_rising ? edge_rise : edge_fall;
  assign port_event = |(port_rise | port_fall);

  // ****************************************************************
  // Core control register
  // ****************************************************************
  // Event set wins over a software write in the same cycle, so an event that
  // lands while software clears its flag is never lost
  function automatic logic sticky_next(input logic q, input logic hw_set, input logic sw_wr,
                                       input logic sw_bit);
    if (hw_set) begin
      sticky_next = 1'b1;
    end else if (sw_wr) begin
      sticky_next = sw_bit;
    end else begin
      sticky_next = q;
    end
  endfunction

  // Enables change only under software control
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      core_en_q <= core_ctrl_reset[7:3];
    end else if (core_wr) begin
      core_en_q <= wbyte[7:3];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      t0_flag_q <= core_ctrl_reset[timer0_overflow_flag_bit];
    end else begin
      t0_flag_q <= sticky_next(t0_flag_q, timer0_overflow, core_wr,
                               wbyte[timer0_overflow_flag_bit]);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      edge_flag_q <= core_ctrl_reset[edge_pin_flag_bit];
    end else begin
      edge_flag_q <= sticky_next(edge_flag_q, edge_event, core_wr,
                                 wbyte[edge_pin_flag_bit]);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port_flag_q <= core_ctrl_reset[port_change_flag_bit];
    end else begin
      port_flag_q <= sticky_next(port_flag_q, port_event, core_wr,
                                 wbyte[port_change_flag_bit]);
    end
  end

  assign core_ctrl = {core_en_q, t0_flag_q, edge_flag_q, port_flag_q};

  // ****************************************************************
  // Undefined bit 0 tracking
  // ****************************************************************
  // Bit 0 reads undefined until first set or write; it is modelled as a known zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      core_bit0_undef_q <= 1'b1;
    end else if (port_event || core_wr) begin
      core_bit0_undef_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Peripheral enables and flags
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      periph_en_q <= periph_en_reset;
    end else if (en_wr) begin
      periph_en_q <= wbyte;
    end
  end

  // Receive and transmit flags follow their buffer levels and are read-only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      periph_flag_q <= periph_flag_reset;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (i == serial_rx_bit || i == serial_tx_bit) begin
          periph_flag_q[i] <= peripheral_levels[i];
        end else begin
          periph_flag_q[i] <= sticky_next(periph_flag_q[i], peripheral_events[i], flag_wr,
                                          wbyte[i]);
        end
      end
    end
  end

  // ****************************************************************
  // Request toward the core
  // ****************************************************************
  // Absent units must have their enable kept clear by software
  assign periph_pairs = periph_flag_q & periph_en_q;

  always_comb begin
    core_req = (core_ctrl[timer0_overflow_en_bit] && core_ctrl[timer0_overflow_flag_bit]) ||
               (core_ctrl[edge_pin_en_bit] && core_ctrl[edge_pin_flag_bit]) ||
               (core_ctrl[port_change_en_bit] && core_ctrl[port_change_flag_bit]);
    periph_req = core_ctrl[peripheral_group_enable_bit] && (|periph_pairs);
  end

  // Stale flags raise a request at once when enabled; software clears first
  assign core_request = core_ctrl[global_request_enable_bit] &&
                        (core_req || periph_req);

  // ****************************************************************
  // Sticky status, mask and interrupt output
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      req_prev_q <= 2'h0;
    end else begin
      req_prev_q <= {periph_req, core_req};
    end
  end

  // Status catches group request edges and ignores the global enable
  assign req_rise = {periph_req, core_req} & ~req_prev_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status_q <= irq_status_reset;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (req_rise[i]) begin
          irq_status_q[i] <= 1'b1;
        end else if (status_wr && wbyte[i]) begin
          irq_status_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_q <= irq_mask_reset;
    end else if (mask_wr) begin
      irq_mask_q <= wbyte[1:0];
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_q <= bus_idle;
    end else begin
      // A request is taken only from idle, so each one gets at most one answer
      case (bus_q)
        bus_idle: begin
          if (wb_cyc_i && wb_stb_i) begin
            bus_q <= bus_ack;
          end
        end
        bus_ack: begin
          bus_q <= bus_idle;
        end
        default: begin
          bus_q <= bus_idle;
        end
      endcase
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Captured when the request is taken, so it stands through the answer cycle
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_core) begin
      rdata_d[7:0] = {core_ctrl[7:1], core_ctrl[port_change_flag_bit] & ~core_bit0_undef_q};
    end else if (hit_en) begin
      rdata_d[7:0] = periph_en_q;
    end else if (hit_flag) begin
      rdata_d[7:0] = periph_flag_q;
    end else if (hit_status) begin
      rdata_d[1:0] = irq_status_q;
    end else if (hit_mask) begin
      rdata_d[1:0] = irq_mask_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (bus_req) begin
      err_q <= !mapped;
      rdata_q <= rdata_d;
    end
  end

  // The answer is gated by the live strobe, so a withdrawn request sees none
  assign wb_ack_o = (bus_q == bus_ack) && !err_q && wb_cyc_i && wb_stb_i;
  assign wb_err_o = (bus_q == bus_ack) && err_q && wb_cyc_i && wb_stb_i;
  assign wb_dat_o = rdata_q;

endmodule

/* verification/irq_enable_props.sv */
// Concurrent checks on the register slave and the core request output
`timescale 1ns/1ps
module irq_enable_props (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic core_request
);
  logic req;
  logic mapped;
  logic core_rd;
  logic pair_seen;
  assign pair_seen = |(wb_dat_o[5:3] & wb_dat_o[2:0]);
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = wb_adr_i inside {8'h0b, 8'h8b, 8'h8c, 8'h0c, 8'h40, 8'h44};
  assign core_rd = wb_ack_o && !wb_we_i && (wb_adr_i == 8'h0b || wb_adr_i == 8'h8b);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ****************
  // Bus slave timing and read data
  // ****************
  mapped_ack_a: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acknowledged next cycle");
  unmapped_err_a: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  ack_pulse_a: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
    else $error("answer longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  idle_quiet_a: assert property (!wb_cyc_i [*2] |-> !wb_ack_o && !wb_err_o)
    else $error("answer while bus idle");
  err_data_a: assert property (wb_err_o && !wb_we_i |-> wb_dat_o == 32'h0)
    else $error("refused read returned data");
  upper_zero_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  // Enables and flag clears need a write, so a read shows live enables and pending flags
  gie_off_a: assert property (core_rd && !wb_dat_o[7] |-> !core_request)
    else $error("request with global enable clear");
  core_pair_a: assert property (core_rd && wb_dat_o[7] && pair_seen
    |-> core_request)
    else $error("enabled pending pair gave no request");
endmodule
bind mcu_irq_enable_logic irq_enable_props u_irq_enable_props (.ref_clk, .resetn, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .core_request);

/* verification/event_source_model.sv */
// Model of the timer and peripheral event sources beside the block
`timescale 1ns/1ps
module event_source_model (
  input wire logic ref_clk,
  output logic timer0_overflow,
  output logic [7:0] peripheral_events,
  output logic [7:0] peripheral_levels
);
  initial begin
    timer0_overflow = 1'b0;
    peripheral_events = 8'h00;
    peripheral_levels = 8'h00;
  end
  // Events last one clock; buffer full/empty are levels held until calm
  task automatic fire(input int b);
    @(posedge ref_clk);
    if (b < 0) timer0_overflow <= 1'b1;
    else if (b == 4 || b == 5) peripheral_levels[b] <= 1'b1;
    else peripheral_events[b] <= 1'b1;
    @(posedge ref_clk);
    timer0_overflow <= 1'b0;
    peripheral_events <= 8'h00;
  endtask
  task automatic calm();
    @(posedge ref_clk);
    peripheral_levels <= 8'h00;
  endtask
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the interrupt enable and flag logic
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, wb_err_o, core_request, irq, timer0_overflow, err;
  logic external_edge_pin = 1'b0, edge_rising = 1'b1;
  logic [3:0] port_upper_pins = 4'h0;
  logic [7:0] peripheral_events, peripheral_levels;
  int failures = 0, num_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  mcu_irq_enable_logic u_mcu_irq_enable_logic (.ref_clk, .resetn, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .timer0_overflow, .external_edge_pin, .edge_rising, .port_upper_pins,
    .peripheral_events, .peripheral_levels, .core_request, .irq);
  event_source_model u_event_source_model (.ref_clk, .timer0_overflow, .peripheral_events,
    .peripheral_levels);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Request held until an answer is seen at a rising edge, bounded wait
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    err = wb_err_o;
    if (n == 50) failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    bus(1'b1, adr, d);
  endtask
  task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    report_and_stop();
  end
  // *************
  // Main sequence
  // *************
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rdchk(8'h0b, 8'h00);
    rdchk(8'h8c, 8'h00);
    rdchk(8'h0c, 8'h00);
    wr(8'h8b, 8'h38);
    rdchk(8'h0b, 8'h38);
    wr(8'h8c, 8'ha5);
    rdchk(8'h8c, 8'ha5);
    wr(8'h8c, 8'h00);
    rdchk(8'h20, 8'h00);
    chk(err, 1'b1);
    wr(8'h0b, 8'h00);
    wr(8'h44, 8'h03);
    u_event_source_model.fire(-1);
    repeat (2) @(posedge ref_clk);
    rdchk(8'h0b, 8'h04);
    chk(core_request, 1'b0);
    wr(8'h0b, 8'ha4);
    chk(core_request, 1'b1);
    rdchk(8'h0b, 8'ha4);
    chk(irq, 1'b1);
    wr(8'h44, 8'h00);
    chk(irq, 1'b0);
    wr(8'h44, 8'h03);
    chk(irq, 1'b1);
    wr(8'h0b, 8'ha0);
    chk(core_request, 1'b0);
    wr(8'h40, 8'h01);
    chk(irq, 1'b0);
    external_edge_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rdchk(8'h0b, 8'ha2);
    port_upper_pins <= 4'h8;
    repeat (6) @(posedge ref_clk);
    rdchk(8'h0b, 8'ha3);
    wr(8'h0b, 8'h00);
    rdchk(8'h0b, 8'h00);
    edge_rising <= 1'b0;
    external_edge_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rdchk(8'h0b, 8'h02);
    for (int b = 0; b < 8; b++) begin
      wr(8'h0c, 8'h00);
      wr(8'h8c, 8'h01 << b);
      wr(8'h0b, 8'h80);
      u_event_source_model.fire(b);
      repeat (2) @(posedge ref_clk);
      chk(core_request, 1'b0);
      rdchk(8'h0c, 8'h01 << b);
      wr(8'h0b, 8'hc0);
      chk(core_request, 1'b1);
      wr(8'h8c, 8'h00);
      chk(core_request, 1'b0);
      u_event_source_model.calm();
    end
    report_and_stop();
  end
endmodule
